// ===== shutter_gpo_map.svh
// register map, field positions, reset values and counts of the shutter and general output block
// assumes word-indexed registers on a 32-bit bus, byte address four times the index
//
// Functional notes
// - skip-first option drops masking in first field
// - wait programmed lines after gate line
// - emit programmed pulse count each field
// - inhibit gate pulse, train runs to count
// - shutter waveform starts at start level bit
// - shutter level flips at two toggle positions
// - separate fine waveform with own toggle pair
// - eight general signals start at own level
// - pins 1-3 select general or internal signal
// - pin4 inverted shutter, pins 5-8 vertical clocks
// - pin driven only while enable bit set
// - input override replaces internal control signals while pin not driven
// - per-output enable selects truth table result
// - pair truth table indexed by second,first
// - toggle matched on field, line, pixel
// - fine toggles update at gate or sync line
`ifndef SHUTTER_GPO_MAP_SVH
`define SHUTTER_GPO_MAP_SVH

`define IDX_MASK_CTRL 8'h74
`define IDX_PULSE_CTRL 8'h75
`define IDX_START_LEVEL 8'h76
`define IDX_TOGGLE_PAIR 8'h77
`define IDX_FINE_TOGGLE 8'h78
`define IDX_TEST_WORD 8'h79
`define IDX_PIN_CTRL 8'h7a
`define IDX_TRUTH_TABLES 8'h7b
`define IDX_T1_FIELD_LINE 8'h7c
`define IDX_T1_PIXEL 8'h7d

`define WMASK_MASK_CTRL 32'h0c00_0000
`define WMASK_PULSE_CTRL 32'h0fff_ffff
`define WMASK_START_LEVEL 32'h0000_0003
`define WMASK_TOGGLE 32'h0fff_ffff
`define WMASK_TEST_WORD 32'h03ff_ffff
`define WMASK_PIN_CTRL 32'h0fff_ffff
`define WMASK_TRUTH_TABLES 32'h00ff_ffff
`define WMASK_T1_FIELD_LINE 32'h03ff_ffff
`define WMASK_T1_PIXEL 32'h0000_1fff

`define RST_MASK_CTRL 32'h0400_0000
`define RST_PIN_CTRL 32'h0000_ff00

`define BIT_UPDATE_SELECT 26
`define BIT_SKIP_FIRST 27
`define LSB_START_DELAY 1
`define LSB_PULSE_COUNT 14
`define BIT_GATE_INHIBIT 27
`define BIT_START_LEVEL 0
`define LSB_TOGGLE_A 0
`define LSB_TOGGLE_B 14
`define LSB_SIGNAL_LEVEL 0
`define LSB_SOURCE_SELECT 8
`define LSB_DRIVE_ENABLE 16
`define LSB_INPUT_OVERRIDE 24
`define LSB_TABLE_ENABLE 0
`define LSB_TABLES 8
`define LSB_T1_FIELD 0
`define LSB_T1_LINE 13
`define LSB_T1_PIXEL 0

`define COORD_W 13
`define TOGGLE_W 14
`define ACK_LATENCY 1

`endif

// ===== shutter_gpo_pkg.sv
// types shared by the shutter and general output block
// assumes nothing beyond a SystemVerilog compiler
package shutter_gpo_pkg;
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_DELAY = 2'b01,
    SH_RUN = 2'b10
  } shutter_state_t;
  typedef logic [12:0] coord_t;
  typedef logic [31:0] word_t;
endpackage : shutter_gpo_pkg

// ===== shutter_gpo_ctrl.sv
// shutter pulse generator and eight general outputs with a classic wishbone register slave
// assumes timing strobes are one-cycle pulses synchronous to clk_i, pixel rate equals clk_i
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "shutter_gpo_map.svh"
module shutter_gpo_ctrl #(
  parameter int ADR_W = 10
) (
  input wire logic clk_i, // 10 MHz clock, one pixel per cycle
  input wire logic rst_i, // synchronous reset, active high
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write
  input wire logic [3:0] sel_i, // wishbone byte selects
  input wire logic [ADR_W-1:0] adr_i, // wishbone byte address
  input wire shutter_gpo_pkg::word_t dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic vertical_sync_i, // field start pulse
  input wire logic line_start_i, // line start pulse
  input wire logic vertical_sensor_gate_line_i, // sensor gate line pulse
  input wire logic update_line_i, // sync update line pulse
  input wire logic sequence_start_i, // restarts general signals and field count
  input wire logic sensor_gate_i, // sensor gate pulse from the vertical timing
  input wire logic shutter_mask_i, // masking requested by exposure control
  input wire logic [7:1] toggle_event_i, // toggle strobes of signals 2 to 8
  input wire logic [2:0] internal_signal_i, // internal signals for pins 1 to 3
  input wire logic [3:0] vertical_clock_i, // vertical clocks 21 to 24
  input wire logic [3:0] internal_ctrl_i, // output control, hblank, clamp, precharge blank
  input wire logic [7:0] pin_i, // pin input levels
  output logic [7:0] pin_o, // pin output levels
  output logic [7:0] pin_oe_o, // pin drive enables
  output logic [3:0] ctrl_o, // control signals after override
  output logic sensor_gate_o, // sensor gate after inhibit
  output logic substrate_clock_o, // shutter waveform
  output logic fine_substrate_clock_o // fine shutter waveform
);
  import shutter_gpo_pkg::*;

  word_t reg_mask_ctrl, reg_pulse_ctrl, reg_start_level, reg_toggle, reg_fine;
  word_t reg_test, reg_pin, reg_tables, reg_t1_fl, reg_t1_px;
  word_t next_mask_ctrl, next_pulse_ctrl, next_start_level, next_toggle, next_fine;
  word_t next_test, next_pin, next_tables, next_t1_fl, next_t1_px;

  // copies that the waveform logic actually uses
  word_t act_pulse_ctrl, act_start_level, act_toggle, act_fine, act_pin, act_tables, act_t1_fl, act_t1_px;
  word_t next_act_pulse_ctrl, next_act_start_level, next_act_toggle, next_act_fine;
  word_t next_act_pin, next_act_tables, next_act_t1_fl, next_act_t1_px;
  logic act_skip, next_act_skip;

  logic next_ack;
  logic [31:0] next_dat;

  coord_t pixel_cnt, line_cnt, field_cnt;
  coord_t next_pixel_cnt, next_line_cnt, next_field_cnt;

  shutter_state_t sh_state, next_sh_state;
  coord_t lines_left, next_lines_left, pulses_done, next_pulses_done;
  logic sub_lvl, next_sub_lvl, fine_lvl, next_fine_lvl, mask_prev, next_mask_prev;
  logic mask_first, next_mask_first, sg_out, next_sg_out;

  logic [7:0] gp, next_gp, pin_q, next_pin_q, oe_q, next_oe_q;
  logic [3:0] ctrl_q, next_ctrl_q;

  logic req;
  logic [7:0] idx;
  word_t wmask;
  word_t rdata;
  logic masked;
  logic [`TOGGLE_W-1:0] pix14;
  logic t1_match;
  logic [3:0] table_res;
  logic [7:0] src;
  logic [7:0] internal_sel;
  logic [3:0] pair_tab;

  assign req = cyc_i && stb_i && !ack_o;
  assign idx = adr_i[9:2];
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign pix14 = {1'b0, pixel_cnt};

  // byte-lane merge clipped to the implemented bits
  function automatic word_t merge(input word_t old, input word_t wd, input word_t lanes, input word_t imp);
    merge = ((old & ~lanes) | (wd & lanes)) & imp;
  endfunction : merge

  always_comb begin
    unique case (idx)
      `IDX_MASK_CTRL: rdata = reg_mask_ctrl;
      `IDX_PULSE_CTRL: rdata = reg_pulse_ctrl;
      `IDX_START_LEVEL: rdata = reg_start_level;
      `IDX_TOGGLE_PAIR: rdata = reg_toggle;
      `IDX_FINE_TOGGLE: rdata = reg_fine;
      `IDX_TEST_WORD: rdata = reg_test;
      `IDX_PIN_CTRL: rdata = reg_pin;
      `IDX_TRUTH_TABLES: rdata = reg_tables;
      `IDX_T1_FIELD_LINE: rdata = reg_t1_fl;
      `IDX_T1_PIXEL: rdata = reg_t1_px;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // register slave: one wait state, unmapped reads zero, unmapped writes dropped
  always_comb begin
    next_mask_ctrl = reg_mask_ctrl;
    next_pulse_ctrl = reg_pulse_ctrl;
    next_start_level = reg_start_level;
    next_toggle = reg_toggle;
    next_fine = reg_fine;
    next_test = reg_test;
    next_pin = reg_pin;
    next_tables = reg_tables;
    next_t1_fl = reg_t1_fl;
    next_t1_px = reg_t1_px;
    next_ack = req;
    next_dat = dat_o;
    if (req && !we_i) begin
      next_dat = rdata;
    end
    // write lands at the edge where the master samples ack
    if (cyc_i && stb_i && we_i && ack_o) begin
      unique case (idx)
        `IDX_MASK_CTRL: next_mask_ctrl = merge(reg_mask_ctrl, dat_i, wmask, `WMASK_MASK_CTRL);
        `IDX_PULSE_CTRL: next_pulse_ctrl = merge(reg_pulse_ctrl, dat_i, wmask, `WMASK_PULSE_CTRL);
        `IDX_START_LEVEL: next_start_level = merge(reg_start_level, dat_i, wmask, `WMASK_START_LEVEL);
        `IDX_TOGGLE_PAIR: next_toggle = merge(reg_toggle, dat_i, wmask, `WMASK_TOGGLE);
        `IDX_FINE_TOGGLE: next_fine = merge(reg_fine, dat_i, wmask, `WMASK_TOGGLE);
        `IDX_TEST_WORD: next_test = merge(reg_test, dat_i, wmask, `WMASK_TEST_WORD);
        `IDX_PIN_CTRL: next_pin = merge(reg_pin, dat_i, wmask, `WMASK_PIN_CTRL);
        `IDX_TRUTH_TABLES: next_tables = merge(reg_tables, dat_i, wmask, `WMASK_TRUTH_TABLES);
        `IDX_T1_FIELD_LINE: next_t1_fl = merge(reg_t1_fl, dat_i, wmask, `WMASK_T1_FIELD_LINE);
        `IDX_T1_PIXEL: next_t1_px = merge(reg_t1_px, dat_i, wmask, `WMASK_T1_PIXEL);
        default: begin
        end
      endcase
    end
  end

  // settings other than the update select bit take effect only at their update points
  always_comb begin
    next_act_pulse_ctrl = act_pulse_ctrl;
    next_act_start_level = act_start_level;
    next_act_toggle = act_toggle;
    next_act_fine = act_fine;
    next_act_skip = act_skip;
    next_act_pin = act_pin;
    next_act_tables = act_tables;
    next_act_t1_fl = act_t1_fl;
    next_act_t1_px = act_t1_px;
    if (vertical_sync_i) begin
      next_act_pulse_ctrl = reg_pulse_ctrl;
      next_act_start_level = reg_start_level;
      next_act_toggle = reg_toggle;
      next_act_pin = reg_pin;
      next_act_tables = reg_tables;
      next_act_t1_fl = reg_t1_fl;
      next_act_t1_px = reg_t1_px;
    end
    if ((!reg_mask_ctrl[`BIT_UPDATE_SELECT] && vertical_sensor_gate_line_i) ||
        (reg_mask_ctrl[`BIT_UPDATE_SELECT] && update_line_i)) begin
      next_act_fine = reg_fine;
      next_act_skip = reg_mask_ctrl[`BIT_SKIP_FIRST];
    end
  end

  // running field, line and pixel position
  always_comb begin
    next_pixel_cnt = pixel_cnt + 13'h0001;
    next_line_cnt = line_cnt;
    next_field_cnt = field_cnt;
    if (line_start_i) begin
      next_pixel_cnt = 13'h0000;
      next_line_cnt = line_cnt + 13'h0001;
    end
    if (vertical_sync_i) begin
      next_pixel_cnt = 13'h0000;
      next_line_cnt = 13'h0000;
      next_field_cnt = field_cnt + 13'h0001;
    end
    if (sequence_start_i) begin
      next_field_cnt = 13'h0000;
    end
  end

  assign masked = shutter_mask_i && !(act_skip && mask_first);

  // shutter pulse train: one pulse per line after the programmed delay
  always_comb begin
    next_sh_state = sh_state;
    next_lines_left = lines_left;
    next_pulses_done = pulses_done;
    next_sub_lvl = sub_lvl;
    next_fine_lvl = fine_lvl;
    next_mask_prev = mask_prev;
    next_mask_first = mask_first;
    next_sg_out = sensor_gate_i && !act_pulse_ctrl[`BIT_GATE_INHIBIT];
    if (vertical_sync_i) begin
      next_mask_first = shutter_mask_i && !mask_prev;
      next_mask_prev = shutter_mask_i;
    end
    unique case (sh_state)
      SH_IDLE: begin
        next_sub_lvl = act_start_level[`BIT_START_LEVEL];
        next_fine_lvl = act_start_level[`BIT_START_LEVEL];
      end
      SH_DELAY: begin
        if (line_start_i) begin
          if (lines_left == 13'h0000) begin
            next_sh_state = (act_pulse_ctrl[`LSB_PULSE_COUNT +: `COORD_W] == 13'h0000) ? SH_IDLE : SH_RUN;
            next_pulses_done = 13'h0000;
          end else begin
            next_lines_left = lines_left - 13'h0001;
          end
        end
      end
      SH_RUN: begin
        if (line_start_i) begin
          next_sub_lvl = act_start_level[`BIT_START_LEVEL];
          next_fine_lvl = act_start_level[`BIT_START_LEVEL];
          next_pulses_done = pulses_done + 13'h0001;
          if (pulses_done + 13'h0001 == act_pulse_ctrl[`LSB_PULSE_COUNT +: `COORD_W]) begin
            next_sh_state = SH_IDLE;
          end
        end else if (!masked) begin
          if (pix14 == act_toggle[`LSB_TOGGLE_A +: `TOGGLE_W] ||
              pix14 == act_toggle[`LSB_TOGGLE_B +: `TOGGLE_W]) begin
            next_sub_lvl = !sub_lvl;
          end
          if (pix14 == act_fine[`LSB_TOGGLE_A +: `TOGGLE_W] ||
              pix14 == act_fine[`LSB_TOGGLE_B +: `TOGGLE_W]) begin
            next_fine_lvl = !fine_lvl;
          end
        end
      end
      default: begin
        next_sh_state = SH_IDLE;
      end
    endcase
    // a gate line restarts the train unless the gate is inhibited while the train is not idle
    if (vertical_sensor_gate_line_i && (sh_state == SH_IDLE || !act_pulse_ctrl[`BIT_GATE_INHIBIT])) begin
      next_sh_state = SH_DELAY;
      next_lines_left = act_pulse_ctrl[`LSB_START_DELAY +: `COORD_W];
      next_sub_lvl = act_start_level[`BIT_START_LEVEL];
      next_fine_lvl = act_start_level[`BIT_START_LEVEL];
    end
  end

  assign t1_match = (field_cnt == act_t1_fl[`LSB_T1_FIELD +: `COORD_W]) &&
                    (line_cnt == act_t1_fl[`LSB_T1_LINE +: `COORD_W]) &&
                    (pixel_cnt == act_t1_px[`LSB_T1_PIXEL +: `COORD_W]);

  always_comb begin
    table_res = 4'h0;
    for (int p = 0; p < 4; p++) begin
      pair_tab = act_tables[`LSB_TABLES + 4 * p +: 4];
      table_res[p] = pair_tab[{gp[2 * p + 1], gp[2 * p]}];
    end
  end

  // general signals, source choice and pin drive
  always_comb begin
    next_gp = gp;
    if (sequence_start_i) begin
      next_gp = act_pin[`LSB_SIGNAL_LEVEL +: 8];
    end else begin
      next_gp[0] = gp[0] ^ t1_match;
      next_gp[7:1] = gp[7:1] ^ toggle_event_i;
    end
    internal_sel = {vertical_clock_i, !sub_lvl, internal_signal_i};
    for (int i = 0; i < 8; i++) begin
      src[i] = act_tables[`LSB_TABLE_ENABLE + i] ? table_res[i / 2] : gp[i];
    end
    for (int i = 0; i < 8; i++) begin
      next_pin_q[i] = act_pin[`LSB_SOURCE_SELECT + i] ? src[i] : internal_sel[i];
    end
    next_oe_q = act_pin[`LSB_DRIVE_ENABLE +: 8];
    for (int k = 0; k < 4; k++) begin
      next_ctrl_q[k] = (act_pin[`LSB_INPUT_OVERRIDE + k] && !act_pin[`LSB_DRIVE_ENABLE + 4 + k]) ?
                       pin_i[4 + k] : internal_ctrl_i[k];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_mask_ctrl <= `RST_MASK_CTRL;
      reg_pulse_ctrl <= 32'h0000_0000;
      reg_start_level <= 32'h0000_0000;
      reg_toggle <= 32'h0000_0000;
      reg_fine <= 32'h0000_0000;
      reg_test <= 32'h0000_0000;
      reg_pin <= `RST_PIN_CTRL;
      reg_tables <= 32'h0000_0000;
      reg_t1_fl <= 32'h0000_0000;
      reg_t1_px <= 32'h0000_0000;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      reg_mask_ctrl <= next_mask_ctrl;
      reg_pulse_ctrl <= next_pulse_ctrl;
      reg_start_level <= next_start_level;
      reg_toggle <= next_toggle;
      reg_fine <= next_fine;
      reg_test <= next_test;
      reg_pin <= next_pin;
      reg_tables <= next_tables;
      reg_t1_fl <= next_t1_fl;
      reg_t1_px <= next_t1_px;
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_pulse_ctrl <= 32'h0000_0000;
      act_start_level <= 32'h0000_0000;
      act_toggle <= 32'h0000_0000;
      act_fine <= 32'h0000_0000;
      act_skip <= 1'b0;
      act_pin <= `RST_PIN_CTRL;
      act_tables <= 32'h0000_0000;
      act_t1_fl <= 32'h0000_0000;
      act_t1_px <= 32'h0000_0000;
    end else begin
      act_pulse_ctrl <= next_act_pulse_ctrl;
      act_start_level <= next_act_start_level;
      act_toggle <= next_act_toggle;
      act_fine <= next_act_fine;
      act_skip <= next_act_skip;
      act_pin <= next_act_pin;
      act_tables <= next_act_tables;
      act_t1_fl <= next_act_t1_fl;
      act_t1_px <= next_act_t1_px;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pixel_cnt <= 13'h0000;
      line_cnt <= 13'h0000;
      field_cnt <= 13'h0000;
    end else begin
      pixel_cnt <= next_pixel_cnt;
      line_cnt <= next_line_cnt;
      field_cnt <= next_field_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_state <= SH_IDLE;
      lines_left <= 13'h0000;
      pulses_done <= 13'h0000;
      sub_lvl <= 1'b0;
      fine_lvl <= 1'b0;
      mask_prev <= 1'b0;
      mask_first <= 1'b0;
      sg_out <= 1'b0;
    end else begin
      sh_state <= next_sh_state;
      lines_left <= next_lines_left;
      pulses_done <= next_pulses_done;
      sub_lvl <= next_sub_lvl;
      fine_lvl <= next_fine_lvl;
      mask_prev <= next_mask_prev;
      mask_first <= next_mask_first;
      sg_out <= next_sg_out;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gp <= 8'h00;
      pin_q <= 8'h00;
      oe_q <= 8'h00;
      ctrl_q <= 4'h0;
    end else begin
      gp <= next_gp;
      pin_q <= next_pin_q;
      oe_q <= next_oe_q;
      ctrl_q <= next_ctrl_q;
    end
  end

  assign pin_o = pin_q;
  assign pin_oe_o = oe_q;
  assign ctrl_o = ctrl_q;
  assign sensor_gate_o = sg_out;
  assign substrate_clock_o = sub_lvl;
  assign fine_substrate_clock_o = fine_lvl;
endmodule : shutter_gpo_ctrl
`default_nettype wire

// ===== shutter_gpo_asserts.sv
// port checker of the shutter and general output block
// assumes one clock domain, bound onto shutter_gpo_ctrl
`timescale 1ns/1ps
`default_nettype none
module shutter_gpo_asserts (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic cyc_i, // bus cycle
  input wire logic stb_i, // bus strobe
  input wire logic ack_o, // bus acknowledge
  input wire logic [31:0] dat_o, // read data
  input wire logic vertical_sync_i, // field start
  input wire logic sensor_gate_i, // gate in
  input wire logic [3:0] internal_ctrl_i, // internal controls
  input wire logic [7:0] pin_oe_o, // drive enables
  input wire logic [3:0] ctrl_o, // controls out
  input wire logic sensor_gate_o, // gate out
  input wire logic substrate_clock_o // shutter out
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence
  property p_ack_after_req;
    s_req |=> s_ans;
  endproperty
  a_ack_after_req: assert property (p_ack_after_req) else $error("no single ack after request");
  property p_ack_has_req;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  a_ack_has_req: assert property (p_ack_has_req) else $error("ack without request");
  property p_no_ack_idle;
    !(cyc_i && stb_i) |=> !ack_o;
  endproperty
  a_no_ack_idle: assert property (p_no_ack_idle) else $error("ack while bus idle");
  property p_dat_hold;
    !ack_o |-> $stable(dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
  property p_out_reset;
    $fell(rst_i) |-> pin_oe_o == 8'h00 && ctrl_o == 4'h0 && !substrate_clock_o;
  endproperty
  a_out_reset: assert property (p_out_reset) else $error("outputs not quiet after reset");
  property p_oe_at_sync;
    !$stable(pin_oe_o) |-> $past(vertical_sync_i) || $past(vertical_sync_i, 2);
  endproperty
  a_oe_at_sync: assert property (p_oe_at_sync) else $error("drive enable moved off field start");
  property p_gate_copy;
    sensor_gate_o |-> $past(sensor_gate_i);
  endproperty
  a_gate_copy: assert property (p_gate_copy) else $error("gate pulse without gate input");
  property p_ctrl_follow;
    pin_oe_o[7:4] == 4'hf && !vertical_sync_i && !$past(vertical_sync_i) |=> ctrl_o == $past(internal_ctrl_i);
  endproperty
  a_ctrl_follow: assert property (p_ctrl_follow) else $error("driven pins overrode controls");
endmodule : shutter_gpo_asserts
bind shutter_gpo_ctrl shutter_gpo_asserts chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .dat_o(dat_o), .vertical_sync_i(vertical_sync_i), .sensor_gate_i(sensor_gate_i),
  .internal_ctrl_i(internal_ctrl_i), .pin_oe_o(pin_oe_o), .ctrl_o(ctrl_o), .sensor_gate_o(sensor_gate_o),
  .substrate_clock_o(substrate_clock_o));
`default_nettype wire

// ===== pin_partner.sv
// far side of the eight general pins: loads and external drivers
// assumes the block's split pin ports and the bench clock
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input wire logic clk_i, // clock
  input wire logic [7:0] pin_o, // block levels
  input wire logic [7:0] pin_oe_o, // block enables
  input wire logic [7:0] ext_en_i, // far side drives
  input wire logic [7:0] ext_val_i, // far side levels
  output logic [7:0] pin_lvl_o // resolved pin levels
);
  logic [7:0] churn;
  initial churn = 8'h55;
  always @(posedge clk_i) churn <= ~churn;
  // floating pins show a changing pattern, never a stale level
  always_comb pin_lvl_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_val_i) | (~pin_oe_o & ~ext_en_i & churn);
endmodule : pin_partner
`default_nettype wire

// ===== test_shutter_pulse_and_gpo_output.sv
// self-checking bench of the shutter and general output block
// assumes block, checker and pin partner compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "shutter_gpo_map.svh"
module test_shutter_pulse_and_gpo_output;
  import shutter_gpo_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sgi = 1'b0, mask = 1'b0;
  logic [3:0] sel = 4'hf, vclk = 4'h0, ictrl = 4'h0, ctrl_o, ov;
  logic [9:0] adr = 10'h000;
  logic [4:0] ev = 5'h00;
  logic [7:1] tev = 7'h00;
  logic [2:0] isig = 3'h0;
  logic [7:0] ext_en = 8'h00, ext_val = 8'h00, pin_lvl, pin_o, pin_oe_o, oe, sl;
  logic ack_o, sgo, sub, fine;
  word_t dat = 32'h0000_0000, dat_o, q, r, r2, shadow [8'h74:8'h7d], wm [8'h74:8'h7d];
  int n_mismatch = 0, comparisons = 0, cycles = 0, seed = 9436, rises = 0, frises = 0;
  shutter_gpo_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel),
    .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .vertical_sync_i(ev[0]), .line_start_i(ev[1]),
    .vertical_sensor_gate_line_i(ev[2]), .update_line_i(ev[3]), .sequence_start_i(ev[4]), .sensor_gate_i(sgi),
    .shutter_mask_i(mask), .toggle_event_i(tev), .internal_signal_i(isig), .vertical_clock_i(vclk),
    .internal_ctrl_i(ictrl), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .ctrl_o(ctrl_o),
    .sensor_gate_o(sgo), .substrate_clock_o(sub), .fine_substrate_clock_o(fine));
  pin_partner far (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .pin_lvl_o(pin_lvl));
  always #50 clk_i = ~clk_i;
  always @(posedge sub) rises++;
  always @(posedge fine) frises++;
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] idx, input word_t d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] i, input word_t d);
    word_t ln;
    wb(1'b1, i, d);
    ln = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    shadow[i] = (shadow[i] & ~ln) | (d & ln);
  endtask : wr
  task automatic pulse(input logic [4:0] m, input int gap);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 5'h00;
    repeat (gap) @(posedge clk_i);
  endtask : pulse
  function automatic logic [7:0] exp_pins(input logic [7:0] lv, en, input logic [15:0] tb, input logic [7:0] s, in);
    for (int p = 0; p < 8; p++) begin
      exp_pins[p] = s[p] ? (en[p] ? tb[4 * (p / 2) + 2 * lv[p | 1] + lv[p & 6]] : lv[p]) : in[p];
    end
  endfunction : exp_pins
  initial begin
    foreach (shadow[i]) shadow[i] = 32'h0000_0000;
    shadow[8'h74] = `RST_MASK_CTRL;
    shadow[8'h7a] = `RST_PIN_CTRL;
    wm = '{`WMASK_MASK_CTRL, `WMASK_PULSE_CTRL, `WMASK_START_LEVEL, `WMASK_TOGGLE, `WMASK_TOGGLE,
      `WMASK_TEST_WORD, `WMASK_PIN_CTRL, `WMASK_TRUTH_TABLES, `WMASK_T1_FIELD_LINE, `WMASK_T1_PIXEL};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 8'h74; i <= 8'h7d; i++) begin
      wb(1'b0, i[7:0], 32'h0000_0000);
      check("reset value", shadow[i] & wm[i], q);
      r = $random(seed) & wm[i] & ((i == 8'h75) ? 32'hffff_fffe : (i == 8'h76) ? 32'h0000_0001 : 32'hffff_ffff);
      sel <= 4'($random(seed));
      wr(i[7:0], (i == 8'h79) ? 32'h0000_0000 : r);
      wb(1'b0, i[7:0], 32'h0000_0000);
      check("readback", shadow[i] & wm[i], q);
    end
    sel <= 4'hf;
    wb(1'b1, 8'hff, $random(seed));
    wb(1'b0, 8'hff, 32'h0000_0000);
    check("unmapped", 32'h0000_0000, q);
    wr(8'h74, `RST_MASK_CTRL);
    wr(8'h76, 32'h0000_0000);
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      r2 = $random(seed);
      {ictrl, isig, vclk} <= r[18:8];
      ext_en <= 8'hf0;
      ext_val <= {r[26:23], 4'h0};
      oe = (k < 3) ? 8'hff : {4'h0, r[30:27]};
      sl = k[0] ? r2[7:0] : 8'hff;
      wr(8'h7a, {4'h0, r[22:19], oe, sl, r[7:0]});
      wr(8'h7b, {8'h00, r2[31:16], r2[15:8]});
      pulse(5'h01, 0);
      pulse(5'h10, 2);
      check("pin levels", exp_pins(r[7:0], r2[15:8], r2[31:16], sl, {vclk, ~sub, isig}), pin_o);
      check("pin enables", oe, pin_oe_o);
      ov = r[22:19] & ~oe[7:4];
      check("controls", (ov & ext_val[7:4]) | (~ov & ictrl), ctrl_o);
      tev <= 7'h7f;
      @(posedge clk_i);
      tev <= 7'h00;
      repeat (2) @(posedge clk_i);
      check("toggled pins", exp_pins(r[7:0] ^ 8'hfe, r2[15:8], r2[31:16], sl, {vclk, ~sub, isig}), pin_o);
    end
    wr(8'h77, {4'h0, 14'h0006, 14'h0003});
    wr(8'h78, {4'h0, 14'h0007, 14'h0002});
    for (int k = 0; k < 7; k++) begin
      if (k == 4) wr(8'h74, 32'h0800_0000);
      wr(8'h75, {4'h0, k == 2, 13'(1 + k % 3), 13'(k % 3), 1'b0});
      sgi <= 1'b1;
      mask <= (k == 3 || k >= 5);
      pulse(5'h01, 0);
      pulse(5'h08, 1);
      check("gate out", 32'(k != 2), 32'(sgo));
      rises = 0;
      frises = 0;
      pulse(5'h04, 0);
      for (int l = 0; l < 7; l++) begin
        if (l == k % 3) check("delay lines", 0, rises);
        pulse(5'h02, 10);
      end
      check("pulse count", (k == 3 || k == 6) ? 0 : 1 + k % 3, rises);
      if (k != 3 && k != 6) check("fine count", 1 + k % 3, frises);
    end
    give_verdict();
  end
endmodule : test_shutter_pulse_and_gpo_output
`default_nettype wire
